/* core/ccw_watchdog.sv */
// Notes on behaviour
// [R1] While enabled, a transaction running past the timeout is aborted, freeing the channel.
// [R2] Timeout comes from setup bits 7:1, in 2 ms steps, reset value 0x7f.
// [R3] Software must never program a zero timeout; zero is unsupported.
// [R4] Setup bit 0 set suspends the watchdog; no transaction is aborted.
// [R5] Setup bit 0 clear, its reset value, keeps the watchdog timing.
// [R6] Counter clears at transaction start, steps each 2 ms, fires on reaching timeout.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
module ccw_watchdog #(
    parameter int unsigned TICK_CYCLES = ccw_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic txn_start_i,
    input wire logic txn_done_i,
    output logic txn_abort_o,
    output logic txn_busy_o,
    output logic irq_o
);

    // ========================================================================
    // Parameter check
    // ========================================================================
    generate
        if (TICK_CYCLES < 2) begin : g_bad_tick
            $error("ccw_watchdog: TICK_CYCLES must be at least 2");
        end
        if (ccw_pkg::DATA_W != 8 || ccw_pkg::ADDR_W != 8) begin : g_bad_bus
            $error("ccw_watchdog: register bus must be 8 bits wide");
        end
        if (ccw_pkg::TIMEOUT_W + 1 != 8 || ccw_pkg::EVT_W >= 8) begin : g_bad_layout
            $error("ccw_watchdog: setup or event layout does not fit one byte");
        end
        if (ccw_pkg::LIVE_BUSY_BIT < ccw_pkg::TIMEOUT_W) begin : g_bad_live
            $error("ccw_watchdog: busy flag overlaps the live step count");
        end
    endgenerate

    // ========================================================================
    // Declarations
    // ========================================================================
    localparam int unsigned TW = ccw_pkg::TIMEOUT_W;
    localparam int unsigned EW = ccw_pkg::EVT_W;
    // Count stops here rather than wrapping
    localparam logic [TW-1:0] COUNT_MAX = {TW{1'b1}};

    // Register file
    logic [7:0] setup;
    logic [7:0] next_setup;
    logic [EW-1:0] status;
    logic [EW-1:0] next_status;
    logic [EW-1:0] enable;
    logic [EW-1:0] next_enable;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic irq_q;
    logic next_irq;

    // Watchdog engine
    ccw_pkg::ccw_state_t state;
    ccw_pkg::ccw_state_t next_state;
    logic [TW-1:0] count;
    logic [TW-1:0] next_count;
    logic abort_q;
    logic next_abort;

    // Decoded fields and one-cycle events
    logic [TW-1:0] timeout;
    logic wd_off;
    logic expired;
    logic [EW-1:0] events;
    // Event sources, one cycle each
    logic evt_timeout;
    logic evt_done;
    logic evt_restart;

    // Engine status decoded once
    logic active;
    logic saturated;
    logic step;

    // Register strobes qualified by address
    logic wr_setup;
    logic wr_clear;
    logic wr_enable;
    logic rd_setup;
    logic rd_status;
    logic rd_enable;
    logic rd_live;

    // Step ticks from the prescaler
    ccw_tick_if tick_bus ();

    // ========================================================================
    // Field decode
    // ========================================================================
    // Setup fields feed the engine directly
    assign timeout = setup[ccw_pkg::TIMEOUT_MSB:ccw_pkg::TIMEOUT_LSB]; // R2
    assign wd_off = setup[ccw_pkg::OFF_BIT]; // R4

    // ========================================================================
    // Register decode
    // ========================================================================
    // Each strobe is qualified once; holes and the wrong strobe decode to nothing
    assign wr_setup = reg_wr_i && (reg_addr_i == ccw_pkg::ADDR_SETUP);
    assign wr_clear = reg_wr_i && (reg_addr_i == ccw_pkg::ADDR_CLEAR);
    assign wr_enable = reg_wr_i && (reg_addr_i == ccw_pkg::ADDR_ENABLE);
    assign rd_setup = reg_rd_i && (reg_addr_i == ccw_pkg::ADDR_SETUP);
    assign rd_status = reg_rd_i && (reg_addr_i == ccw_pkg::ADDR_STATUS);
    assign rd_enable = reg_rd_i && (reg_addr_i == ccw_pkg::ADDR_ENABLE);
    assign rd_live = reg_rd_i && (reg_addr_i == ccw_pkg::ADDR_LIVE);

    // ========================================================================
    // Engine decode
    // ========================================================================
    // Saturation keeps a very late done from wrapping the count to zero
    assign active = (state == ccw_pkg::CCW_ACTIVE);
    assign saturated = (count == COUNT_MAX);
    assign step = tick_bus.tick && !saturated;

    // ========================================================================
    // Prescaler
    // ========================================================================
    // Held at zero outside a running transaction so each step is a full 2 ms
    assign tick_bus.restart = txn_start_i || !active || wd_off;

    ccw_tick_gen #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .tick_io(tick_bus)
    );

    // ========================================================================
    // Watchdog engine
    // ========================================================================
    // Compare with >= so a timeout lowered below the count still fires.
    // A zero timeout fires at once; software must avoid it.
    assign expired = active && !wd_off
        && (count >= timeout) && !txn_done_i; // R1 R3 R6

    // Next state, step count and abort pulse
    always_comb begin
        next_state = state;
        next_count = count;
        next_abort = 1'b0;
        case (state)
            ccw_pkg::CCW_IDLE: begin
                if (txn_start_i) begin
                    next_state = ccw_pkg::CCW_ACTIVE;
                    next_count = '0; // R6
                end
            end
            ccw_pkg::CCW_ACTIVE: begin
                if (txn_start_i) begin
                    // A new transaction retimes from zero
                    next_count = '0; // R6
                end else if (txn_done_i) begin
                    next_state = ccw_pkg::CCW_IDLE;
                    next_count = '0;
                end else if (wd_off) begin
                    // Suspended: count held at zero, nothing is aborted
                    next_count = '0; // R4
                end else if (expired) begin
                    // Release the channel for the next transaction
                    next_state = ccw_pkg::CCW_IDLE; // R1
                    next_count = '0;
                    next_abort = 1'b1; // R1
                end else if (step) begin
                    next_count = count + 1'b1; // R5 R6
                end
            end
            default: begin
                next_state = ccw_pkg::CCW_IDLE;
                next_count = '0;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ccw_pkg::CCW_IDLE;
            count <= '0;
            abort_q <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            abort_q <= next_abort;
        end
    end

    // ========================================================================
    // Interrupt events
    // ========================================================================
    // Restart event flags a start landing on a transaction still running
    assign evt_timeout = next_abort; // R1
    assign evt_done = active && txn_done_i && !txn_start_i;
    assign evt_restart = active && txn_start_i;

    // Gather the sources into the status layout
    always_comb begin
        events = '0;
        events[ccw_pkg::EVT_TIMEOUT] = evt_timeout;
        events[ccw_pkg::EVT_DONE] = evt_done;
        events[ccw_pkg::EVT_RESTART] = evt_restart;
    end

    // ========================================================================
    // Register file
    // ========================================================================
    // Writes and sticky status; a new event beats a clear in the same cycle
    always_comb begin
        next_setup = setup;
        next_enable = enable;
        next_status = status;
        if (wr_setup) begin
            // Timeout and off bit land together
            next_setup = reg_wdata_i; // R2 R4 R5
        end
        if (wr_enable) begin
            // Mask only; status keeps collecting events
            next_enable = reg_wdata_i[EW-1:0];
        end
        if (wr_clear) begin
            // Write-one-to-clear; zero bits leave their flag alone
            next_status = status & ~reg_wdata_i[EW-1:0];
        end
        next_status = next_status | events;
        // Level interrupt follows the status on the same edge
        next_irq = |(next_status & next_enable);
    end

    // Control flops; setup resets to a 0x7f timeout, watchdog on
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            setup <= ccw_pkg::SETUP_RESET; // R2 R5
            enable <= ccw_pkg::EVT_RESET;
            status <= ccw_pkg::EVT_RESET;
            irq_q <= 1'b0;
        end else begin
            setup <= next_setup;
            enable <= next_enable;
            status <= next_status;
            irq_q <= next_irq;
        end
    end

    // ========================================================================
    // Read data
    // ========================================================================
    // One-hot select; clear register and holes read as zero
    always_comb begin
        next_rdata = '0;
        if (rd_setup) begin
            next_rdata = setup;
        end
        if (rd_status) begin
            // Bits above the event field stay zero
            next_rdata[EW-1:0] = status;
        end
        if (rd_enable) begin
            next_rdata[EW-1:0] = enable;
        end
        if (rd_live) begin
            // Busy flag over the elapsed step count, for software polling
            next_rdata[ccw_pkg::LIVE_BUSY_BIT] = active;
            next_rdata[TW-1:0] = count;
        end
    end

    // Read data stands one cycle, then drops back to zero
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // All outputs come straight from flip-flops
    assign reg_rdata_o = rdata;
    // Registered so the channel logic sees a clean one-cycle pulse
    assign txn_abort_o = abort_q; // R1
    // Busy is the state bit itself, no decode glitch
    assign txn_busy_o = active;
    assign irq_o = irq_q;

endmodule : ccw_watchdog

/* core/ccw_pkg.sv */
package ccw_pkg;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 2;
    // Core cycles in one 2 ms timeout step
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_ENABLE = 8'h0c;
    localparam logic [7:0] ADDR_LIVE = 8'h10;

    // ========================================================================
    // Field layout of the setup register
    // ========================================================================
    localparam int unsigned TIMEOUT_LSB = 1;
    localparam int unsigned TIMEOUT_MSB = 7;
    localparam int unsigned TIMEOUT_W = TIMEOUT_MSB - TIMEOUT_LSB + 1;
    localparam int unsigned OFF_BIT = 0;
    // Timeout 0x7f, watchdog running
    localparam logic [7:0] SETUP_RESET = 8'hfe;

    // ========================================================================
    // Event bits of status, clear and enable
    // ========================================================================
    localparam int unsigned EVT_TIMEOUT = 0;
    localparam int unsigned EVT_DONE = 1;
    localparam int unsigned EVT_RESTART = 2;
    localparam int unsigned EVT_W = 3;
    localparam logic [2:0] EVT_RESET = 3'h0;

    // ========================================================================
    // Live register layout
    // ========================================================================
    localparam int unsigned LIVE_BUSY_BIT = 7;

    // ========================================================================
    // Watchdog states
    // ========================================================================
    typedef enum logic [0:0] {
        CCW_IDLE = 1'b0,
        CCW_ACTIVE = 1'b1
    } ccw_state_t;

endpackage : ccw_pkg

/* core/ccw_tick_if.sv */
// ============================================================================
// Step tick between the watchdog and its prescaler
// ============================================================================
interface ccw_tick_if;
    logic restart;
    logic tick;
    modport gen (input restart, output tick);
    modport user (output restart, input tick);
endinterface : ccw_tick_if

/* core/ccw_tick_gen.sv */
module ccw_tick_gen #(
    parameter int unsigned CYCLES = ccw_pkg::TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    ccw_tick_if.gen tick_io
);

    // ========================================================================
    // Parameter check
    // ========================================================================
    localparam int unsigned CNT_W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

    generate
        if (CYCLES < 2) begin : g_bad_cycles
            $error("ccw_tick_gen: CYCLES must be at least 2");
        end
    endgenerate

    // ========================================================================
    // Prescaler
    // ========================================================================
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic tick_q;
    logic next_tick;

    // Restart aligns the first step to the start of the transaction
    always_comb begin
        next_cnt = cnt + 1'b1;
        next_tick = 1'b0;
        if (tick_io.restart) begin
            next_cnt = '0;
        end else if (cnt == LAST) begin
            next_cnt = '0;
            next_tick = 1'b1;
        end
    end

    // State registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick_q <= next_tick;
        end
    end

    assign tick_io.tick = tick_q;

endmodule : ccw_tick_gen

/* test/ccw_watchdog_assertions.sv */
module ccw_watchdog_assertions #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic txn_start_i,
    input wire logic txn_done_i,
    input wire logic txn_abort_o,
    input wire logic txn_busy_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================================================
    // Shadow of setup and cycles since the last start
    // ========================================================================
    logic [7:0] setup;
    logic [7:0] next_setup;
    logic [15:0] cyc;
    logic [15:0] next_cyc;
    logic [15:0] lim;
    // Abort cycle, counted from the start cycle
    assign lim = 16'(setup[7:1]) * 16'(TICK_CYCLES) + 16'h0003;
    // Snoop writes; track elapsed cycles while busy
    always_comb begin
        next_setup = setup;
        next_cyc = cyc;
        if (reg_wr_i && reg_addr_i == ccw_pkg::ADDR_SETUP) next_setup = reg_wdata_i;
        if (txn_start_i) next_cyc = 16'h0001;
        else if (txn_busy_o) next_cyc = cyc + 16'h0001;
    end
    // Register the helpers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            setup <= 8'hfe;
            cyc <= 16'h0000;
        end else begin
            setup <= next_setup;
            cyc <= next_cyc;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_abort_pulse: assert property (txn_abort_o |=> !txn_abort_o)
        else $error("abort longer than one cycle");
    a_start_busy: assert property (txn_start_i |=> txn_busy_o)
        else $error("start did not make busy");
    a_abort_time: assert property (txn_abort_o |-> cyc == lim)
        else $error("abort at wrong cycle");
    a_abort_due: assert property (txn_busy_o && !txn_start_i && !txn_done_i
        && !setup[0] && cyc == lim - 16'h0001 |=> txn_abort_o && !txn_busy_o)
        else $error("overdue transaction not aborted");
    a_off_quiet: assert property (setup[0] && $past(setup[0]) |-> !txn_abort_o)
        else $error("abort while watchdog off");
    a_setup_read: assert property (reg_rd_i && reg_addr_i == ccw_pkg::ADDR_SETUP
        |=> reg_rdata_o == setup)
        else $error("setup readback wrong");
    c_abort: cover property (txn_abort_o);
    c_done: cover property (txn_done_i && txn_busy_o);
    c_off_busy: cover property (setup[0] && txn_busy_o);
    c_restart: cover property (txn_start_i && txn_busy_o);
endmodule : ccw_watchdog_assertions

bind ccw_watchdog ccw_watchdog_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .txn_start_i(txn_start_i), .txn_done_i(txn_done_i),
    .txn_abort_o(txn_abort_o), .txn_busy_o(txn_busy_o), .irq_o(irq_o));

/* test/ccw_far_end.sv */
module ccw_far_end (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [15:0] hold_i,
    output logic start_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] left;
    logic [15:0] next_left;
    // Hold 0 never finishes, so a stuck remote side can be staged
    always_comb begin
        next_left = left;
        if (go_i) next_left = hold_i;
        else if (left != 16'h0000) next_left = left - 16'h0001;
    end
    // Start follows a request; done lands hold cycles after start
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            left <= 16'h0000;
            start_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            left <= next_left;
            start_o <= go_i;
            done_o <= !go_i && left == 16'h0001;
        end
    end
endmodule : ccw_far_end

/* test/ccw_watchdog_tb.sv */
module ccw_watchdog_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TC = 4;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic [15:0] hold = 16'h0000;
    logic [7:0] rdata;
    logic start, done, abort, busy, irq;
    logic [31:0] seed = 32'h15;
    int mismatches = 0;
    int checked = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    ccw_watchdog #(.TICK_CYCLES(TC)) u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .txn_start_i(start), .txn_done_i(done),
        .txn_abort_o(abort), .txn_busy_o(busy), .irq_o(irq));
    ccw_far_end u_far (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .go_i(go), .hold_i(hold),
        .start_o(start), .done_o(done));
    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // Done in the deciding cycle still saves the transaction
    function automatic logic exp_abort(int n, int h);
        return h == 0 || h > n * TC + 2;
    endfunction : exp_abort
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 cmp(what, 16'(exp), 16'(rdata));
    endtask : rd_chk
    // One transaction; notes whether and in which cycle it was aborted
    task automatic txn(int h, int len, output logic got, output int at);
        @(posedge clk_sys_i);
        go <= 1'b1;
        hold <= 16'(h);
        @(posedge clk_sys_i);
        go <= 1'b0;
        got = 1'b0;
        at = 0;
        for (int i = 1; i <= len; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (abort === 1'b1) begin
                got = 1'b1;
                at = i;
            end
        end
    endtask : txn
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // ========================================================================
    // Sequence
    // ========================================================================
    initial begin
        logic got;
        int at;
        int n;
        int h;
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd_chk("setup reset", ccw_pkg::ADDR_SETUP, 8'hfe);
        rd_chk("unmapped", 8'h20, 8'h00);
        // Stuck transaction, interrupt masked first
        wr_reg(ccw_pkg::ADDR_SETUP, 8'h02);
        txn(0, TC + 8, got, at);
        cmp("abort", 16'h1, 16'(got));
        cmp("abort cycle", 16'(TC + 3), 16'(at));
        cmp("irq masked", 16'h0, 16'(irq));
        wr_reg(ccw_pkg::ADDR_ENABLE, 8'h01);
        @(posedge clk_sys_i);
        #1 cmp("irq", 16'h1, 16'(irq));
        wr_reg(ccw_pkg::ADDR_CLEAR, 8'h07);
        @(posedge clk_sys_i);
        #1 cmp("irq cleared", 16'h0, 16'(irq));
        // Random timeouts; first hits the deciding cycle exactly, second lands one cycle after
        for (int k = 0; k < 26; k++) begin
            n = 1 + int'(rnd() % 32'h4);
            h = k < 2 ? n * TC + 2 + k : int'(rnd() % 32'(n * TC + 7));
            wr_reg(ccw_pkg::ADDR_SETUP, {7'(n), 1'b0});
            txn(h, n * TC + 8, got, at);
            cmp("abort", 16'(exp_abort(n, h)), 16'(got));
            if (got === 1'b1) cmp("abort cycle", 16'(n * TC + 3), 16'(at));
        end
        // Watchdog off: a long transaction must survive
        wr_reg(ccw_pkg::ADDR_CLEAR, 8'h07);
        wr_reg(ccw_pkg::ADDR_SETUP, 8'h03);
        txn(3 * TC, 3 * TC + 4, got, at);
        cmp("abort while off", 16'h0, 16'(got));
        rd_chk("status", ccw_pkg::ADDR_STATUS, 8'h02);
        // Start on a running transaction retimes it from zero
        wr_reg(ccw_pkg::ADDR_SETUP, 8'h10);
        txn(0, 2, got, at);
        cmp("busy", 16'h1, 16'(busy));
        rd_chk("live", ccw_pkg::ADDR_LIVE, 8'h80);
        txn(0, 8 * TC + 8, got, at);
        cmp("restart abort", 16'h1, 16'(got));
        cmp("restart cycle", 16'(8 * TC + 3), 16'(at));
        cmp("busy after abort", 16'h0, 16'(busy));
        rd_chk("status all", ccw_pkg::ADDR_STATUS, 8'h07);
        rd_chk("enable", ccw_pkg::ADDR_ENABLE, 8'h01);
        cmp("irq held", 16'h1, 16'(irq));
        wr_reg(ccw_pkg::ADDR_SETUP, 8'hfe);
        rd_chk("setup back", ccw_pkg::ADDR_SETUP, 8'hfe);
        end_sim();
    end
    // Hang guard, far beyond the expected run
    initial begin
        #100000;
        mismatches++;
        end_sim();
    end
endmodule : ccw_watchdog_tb
